// >>> src/ifb_top.v
// ISP data holding registers, pulse timing register and boot unlock gate
`timescale 1ns/100ps
// What this block does
// (RL1) Fetched flash byte lands in read data
// (RL2) Data registers need no reset value
// (RL3) Programmed byte comes from write data
// (RL4) Software keeps data and timing steady
// (RL5) Registers reachable from flash or boot code
// (RL6) Pulse width follows the timing register
// (RL7) Software loads timing before any operation
// (RL8) Timing reload only when oscillator changes
// (RL9) Timing codes come from frequency table
// (RL10) Reset loads highest range timing code
// (RL11) Boot firmware defines timing first
// (RL12) No flash execution while programming
// (RL13) Jump-to-boot and return instructions exist
// (RL14) Jump enters boot only when unlocked
// (RL15) Key match sets flag eight cycles
// (RL16) Mismatch leaves flag clear, jump stays
// (RL17) Software jumps within unlock window
// (RL18) Breakpoint in emulation freezes window count
// (RL19) Window keeps counting through interrupts
// (RL20) Disable interrupts around boot entry
// (RL21) Key compares bits 7..2 only
// (RL22) Timing top bit read-only zero
module ifb_top
(
	input  wire        aclk,
	input  wire        aresetn,
	input  wire [4:0]  s_axi_awaddr,
	input  wire [2:0]  s_axi_awprot,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [4:0]  s_axi_araddr,
	input  wire [2:0]  s_axi_arprot,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	output reg         flash_rd_req,
	input  wire        flash_rd_ack,
	input  wire [7:0]  flash_rdata,
	output wire [7:0]  flash_wdata,
	output reg  [1:0]  flash_op,
	output wire        flash_pgm_pulse,
	input  wire        instr_cycle,
	input  wire        emu_mode,
	input  wire        emu_break,
	input  wire        jump_to_boot_instr,
	input  wire        return_to_flash_instr,
	output reg         jump_go_boot,
	output reg         jump_go_flash,
	output reg         exec_from_boot
);
`include "ifb_map.vh"

localparam ST_IDLE  = 2'h0;
localparam ST_RD    = 2'h1;
localparam ST_PULSE = 2'h2;

reg  [4:0]  awaddr_q;
reg         aw_hold_q;
reg  [7:0]  wbyte_q;
reg  [3:0]  wstrb_q;
reg         w_hold_q;
reg  [7:0]  rdata_reg_q;
reg  [7:0]  wdata_reg_q;
reg  [7:0]  program_pulse_timing_q;
reg  [1:0]  state_q;
reg  [2:0]  wsel;
reg  [31:0] rd_mux;
reg         rd_err;
wire        wr_go;
wire        wr_lane0;
wire        key_match;
wire        unlocked;
wire        pulse_done;
wire        pulse_start;
wire        busy;
wire        ctrl_wr;

// ********************************************************************
// Address decode
// ********************************************************************
function [2:0] ifb_decode;
	input [4:0] addr;
	begin
		case (addr)
			`IFB_OFS_RDATA:  ifb_decode = `IFB_SEL_RDATA;
			`IFB_OFS_WDATA:  ifb_decode = `IFB_SEL_WDATA;
			`IFB_OFS_PROGRAM_PULSE_TIMING: ifb_decode = `IFB_SEL_PROGRAM_PULSE_TIMING;
			`IFB_OFS_KEY:    ifb_decode = `IFB_SEL_KEY;
			`IFB_OFS_CTRL:   ifb_decode = `IFB_SEL_CTRL;
			default:         ifb_decode = `IFB_SEL_NONE;
		endcase
	end
endfunction

// ********************************************************************
// AXI4-Lite write channels
// ********************************************************************
// Address and data are held separately so either may arrive first
assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
assign s_axi_wready  = !w_hold_q && !s_axi_bvalid;
assign wr_go         = aw_hold_q && w_hold_q && !s_axi_bvalid;
assign wr_lane0      = wr_go && wstrb_q[0];

always @*
begin
	wsel = ifb_decode(awaddr_q);
end

always @(posedge aclk)
begin
	if (!aresetn)
	begin
		aw_hold_q    <= 1'b0;
		w_hold_q     <= 1'b0;
		awaddr_q     <= 5'h00;
		wbyte_q      <= 8'h00;
		wstrb_q      <= 4'h0;
		s_axi_bvalid <= 1'b0;
		s_axi_bresp  <= `IFB_RESP_OKAY;
	end
	else
	begin
		if (s_axi_awvalid && s_axi_awready)
		begin
			aw_hold_q <= 1'b1;
			awaddr_q  <= s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			w_hold_q <= 1'b1;
			wbyte_q  <= s_axi_wdata[7:0];
			wstrb_q  <= s_axi_wstrb;
		end
		if (wr_go)
		begin
			aw_hold_q    <= 1'b0;
			w_hold_q     <= 1'b0;
			s_axi_bvalid <= 1'b1;
			if (wsel == `IFB_SEL_NONE)
				s_axi_bresp <= `IFB_RESP_SLVERR;
			else
				s_axi_bresp <= `IFB_RESP_OKAY;
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end
end

// ********************************************************************
// Holding and timing registers
// ********************************************************************
// No gating by execution source: flash and boot code reach them alike
assign ctrl_wr = wr_lane0 && (wsel == `IFB_SEL_CTRL);          // [RL5]

always @(posedge aclk)
begin
	if (!aresetn)
	begin
		rdata_reg_q <= 8'h00;                                  // [RL2]
		wdata_reg_q <= 8'h00;                                  // [RL2]
		program_pulse_timing_q    <= `IFB_PROGRAM_PULSE_TIMING_RST;                         // [RL10]
	end
	else
	begin
		if (wr_lane0 && wsel == `IFB_SEL_WDATA)
			wdata_reg_q <= wbyte_q;
		if (wr_lane0 && wsel == `IFB_SEL_PROGRAM_PULSE_TIMING)
			program_pulse_timing_q <= wbyte_q & `IFB_PROGRAM_PULSE_TIMING_RW;               // [RL22] [RL9]
		if (state_q == ST_RD && flash_rd_ack)
			rdata_reg_q <= flash_rdata;                         // [RL1]
	end
end

assign flash_wdata = wdata_reg_q;                              // [RL3]

// ********************************************************************
// AXI4-Lite read channel
// ********************************************************************
assign s_axi_arready = !s_axi_rvalid;

always @*
begin
	rd_mux = 32'h00000000;
	rd_err = 1'b0;
	case (ifb_decode(s_axi_araddr))
		`IFB_SEL_RDATA:  rd_mux[7:0] = rdata_reg_q;
		`IFB_SEL_WDATA:  rd_mux[7:0] = wdata_reg_q;
		`IFB_SEL_PROGRAM_PULSE_TIMING: rd_mux[7:0] = program_pulse_timing_q;
		`IFB_SEL_KEY:    rd_mux[`IFB_ST_UNLOCK] = unlocked;
		`IFB_SEL_CTRL:
		begin
			rd_mux[`IFB_ST_BUSY]   = busy;
			rd_mux[`IFB_ST_UNLOCK] = unlocked;
			rd_mux[`IFB_ST_BOOT]   = exec_from_boot;
		end
		default:         rd_err = 1'b1;
	endcase
end

always @(posedge aclk)
begin
	if (!aresetn)
	begin
		s_axi_rvalid <= 1'b0;
		s_axi_rdata  <= 32'h00000000;
		s_axi_rresp  <= `IFB_RESP_OKAY;
	end
	else if (s_axi_arvalid && s_axi_arready)
	begin
		s_axi_rvalid <= 1'b1;
		s_axi_rdata  <= rd_mux;
		s_axi_rresp  <= rd_err ? `IFB_RESP_SLVERR : `IFB_RESP_OKAY;
	end
	else if (s_axi_rready)
		s_axi_rvalid <= 1'b0;
end

// ********************************************************************
// Flash operation sequencer
// ********************************************************************
// Commands while busy are dropped; software polls the busy bit first
assign busy        = (state_q != ST_IDLE);
assign pulse_start = ctrl_wr && !busy && (wbyte_q[`IFB_CTRL_MERASE:`IFB_CTRL_PGM] != 3'h0);

always @(posedge aclk)
begin
	if (!aresetn)
	begin
		state_q      <= ST_IDLE;
		flash_rd_req <= 1'b0;
		flash_op     <= `IFB_OP_NONE;
	end
	else
	begin
		flash_rd_req <= 1'b0;
		case (state_q)
			ST_IDLE:
			begin
				if (ctrl_wr && wbyte_q[`IFB_CTRL_RD])
				begin
					flash_rd_req <= 1'b1;
					state_q      <= ST_RD;
				end
				else if (pulse_start)
				begin
					state_q <= ST_PULSE;
					if (wbyte_q[`IFB_CTRL_PGM])
						flash_op <= `IFB_OP_PGM;
					else if (wbyte_q[`IFB_CTRL_PERASE])
						flash_op <= `IFB_OP_PERASE;
					else
						flash_op <= `IFB_OP_MERASE;
				end
			end
			ST_RD:
			begin
				if (flash_rd_ack)
					state_q <= ST_IDLE;
			end
			ST_PULSE:
			begin
				if (pulse_done)
				begin
					state_q  <= ST_IDLE;
					flash_op <= `IFB_OP_NONE;
				end
			end
			default:
				state_q <= ST_IDLE;
		endcase
	end
end

ifb_pulse_timer u_pulse
(
	.aclk    (aclk),
	.aresetn (aresetn),
	.start   (pulse_start && !wbyte_q[`IFB_CTRL_RD]),
	.code    (program_pulse_timing_q[6:0]),
	.pulse   (flash_pgm_pulse),
	.done    (pulse_done)
);

// ********************************************************************
// Boot unlock and jump steering
// ********************************************************************
// Low two bits of the key byte are don't-care
assign key_match = wr_lane0 && (wsel == `IFB_SEL_KEY) &&
	(wbyte_q[7:2] == `IFB_KEY_PATTERN);                        // [RL21] [RL16]

ifb_unlock_window u_unlock
(
	.aclk        (aclk),
	.aresetn     (aresetn),
	.arm         (key_match),
	.instr_cycle (instr_cycle),
	.freeze      (emu_mode && emu_break),
	.unlocked    (unlocked)
);

always @(posedge aclk)
begin
	if (!aresetn)
	begin
		jump_go_boot   <= 1'b0;
		jump_go_flash  <= 1'b0;
		exec_from_boot <= 1'b0;
	end
	else
	begin
		jump_go_boot  <= jump_to_boot_instr && unlocked;        // [RL14] [RL13]
		jump_go_flash <= jump_to_boot_instr && !unlocked;       // [RL16]
		if (jump_to_boot_instr && unlocked)
			exec_from_boot <= 1'b1;                             // [RL13]
		else if (return_to_flash_instr)
			exec_from_boot <= 1'b0;                             // [RL13]
	end
end

endmodule

// >>> pkg/ifb_map.vh
// Register offsets, field positions, reset values and timing counts of the ISP block
`ifndef IFB_MAP_VH
`define IFB_MAP_VH

// ********************************************************************
// Register byte offsets
// ********************************************************************
`define IFB_OFS_RDATA     5'h00
`define IFB_OFS_WDATA     5'h04
`define IFB_OFS_PROGRAM_PULSE_TIMING    5'h08
`define IFB_OFS_KEY       5'h0c
`define IFB_OFS_CTRL      5'h10
`define IFB_ADDR_W        5

// ********************************************************************
// Decoded register indices
// ********************************************************************
`define IFB_SEL_RDATA     3'h0
`define IFB_SEL_WDATA     3'h1
`define IFB_SEL_PROGRAM_PULSE_TIMING    3'h2
`define IFB_SEL_KEY       3'h3
`define IFB_SEL_CTRL      3'h4
`define IFB_SEL_NONE      3'h7

// ********************************************************************
// Fields and reset values
// ********************************************************************
`define IFB_PROGRAM_PULSE_TIMING_RST    8'h7b
`define IFB_PROGRAM_PULSE_TIMING_RW     8'h7f
`define IFB_KEY_PATTERN   6'h26
`define IFB_CTRL_RD       0
`define IFB_CTRL_PGM      1
`define IFB_CTRL_PERASE   2
`define IFB_CTRL_MERASE   3
`define IFB_ST_BUSY       0
`define IFB_ST_UNLOCK     1
`define IFB_ST_BOOT       2

// ********************************************************************
// Flash operation codes
// ********************************************************************
`define IFB_OP_PGM        2'h1
`define IFB_OP_PERASE     2'h2
`define IFB_OP_MERASE     2'h3
`define IFB_OP_NONE       2'h0

// ********************************************************************
// Timing and bus answers
// ********************************************************************
`define IFB_KEY_CYCLES    4'h8
`define IFB_PULSE_UNIT    8'h10
`define IFB_RESP_OKAY     2'h0
`define IFB_RESP_SLVERR   2'h2

`endif

// >>> src/ifb_unlock_window.v
// Boot unlock window: flag held for a fixed count of instruction cycles
`timescale 1ns/100ps
module ifb_unlock_window
(
	input  wire       aclk,
	input  wire       aresetn,
	input  wire       arm,
	input  wire       instr_cycle,
	input  wire       freeze,
	output wire       unlocked
);
`include "ifb_map.vh"

reg  [3:0] cnt_q;
reg  [3:0] cnt_d;

// ********************************************************************
// Instruction cycle counter
// ********************************************************************
// Interrupts do not stop the count, so a serviced interrupt eats the window
always @*
begin
	cnt_d = cnt_q;
	if (arm)
		cnt_d = `IFB_KEY_CYCLES;                            // [RL15]
	else if (cnt_q != 4'h0 && instr_cycle && !freeze)   // [RL18] [RL19]
		cnt_d = cnt_q - 4'h1;
end

always @(posedge aclk)
begin
	if (!aresetn)
		cnt_q <= 4'h0;
	else
		cnt_q <= cnt_d;
end

assign unlocked = (cnt_q != 4'h0);                      // [RL15]

endmodule

// >>> src/ifb_pulse_timer.v
// Program and erase pulse generator sized by the timing code
`timescale 1ns/100ps
module ifb_pulse_timer
(
	input  wire       aclk,
	input  wire       aresetn,
	input  wire       start,
	input  wire [6:0] code,
	output wire       pulse,
	output reg        done
);
`include "ifb_map.vh"

reg  [14:0] cnt_q;

// ********************************************************************
// Pulse counter
// ********************************************************************
// Width scales with the code, so a slow oscillator gets a long pulse
always @(posedge aclk)
begin
	if (!aresetn)
	begin
		cnt_q <= 15'h0000;
		done  <= 1'b0;
	end
	else
	begin
		done <= 1'b0;
		if (start && cnt_q == 15'h0000)
			cnt_q <= {8'h00, code} * {7'h00, `IFB_PULSE_UNIT};  // [RL6]
		else if (cnt_q != 15'h0000)
		begin
			cnt_q <= cnt_q - 15'h0001;
			if (cnt_q == 15'h0001)
				done <= 1'b1;
		end
	end
end

assign pulse = (cnt_q != 15'h0000);

endmodule

// >>> verification/ifb_monitor.sv
// Port checker for the ISP block
`timescale 1ns/100ps
module ifb_monitor
(
	input wire        aclk,
	input wire        aresetn,
	input wire [1:0]  s_axi_bresp,
	input wire        s_axi_bvalid,
	input wire        s_axi_bready,
	input wire [31:0] s_axi_rdata,
	input wire        s_axi_rvalid,
	input wire        s_axi_rready,
	input wire        flash_rd_req,
	input wire [1:0]  flash_op,
	input wire        flash_pgm_pulse,
	input wire        jump_to_boot_instr,
	input wire        return_to_flash_instr,
	input wire        jump_go_boot,
	input wire        jump_go_flash,
	input wire        exec_from_boot
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	sequence s_jump;
		jump_to_boot_instr && !return_to_flash_instr;
	endsequence
	sequence s_one_go;
		jump_go_boot ^ jump_go_flash;
	endsequence
	a_pulse_has_op: assert property (flash_pgm_pulse |-> flash_op != 2'h0)
		else $error("pulse without op");
	a_pulse_ends_op: assert property ($fell(flash_pgm_pulse) |-> ##[0:1] flash_op == 2'h0)
		else $error("op stays after pulse");
	a_rd_req_once: assert property (flash_rd_req |=> !flash_rd_req)
		else $error("read request too long");
	a_jump_answers: assert property (s_jump |=> s_one_go)
		else $error("jump not answered once");
	a_no_stray_go: assert property (!$past(jump_to_boot_instr) |-> !(jump_go_boot || jump_go_flash))
		else $error("jump answer without jump");
	a_boot_sets_exec: assert property (jump_go_boot |-> exec_from_boot)
		else $error("boot jump without boot exec");
	a_return_clears: assert property (return_to_flash_instr && !jump_to_boot_instr |=> !exec_from_boot)
		else $error("return kept boot exec");
	a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped");
	a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped");
endmodule
bind ifb_top ifb_monitor mon (.*);

// >>> verification/ifb_flash_model.sv
// Flash array model answering byte reads
`timescale 1ns/100ps
module ifb_flash_model
(
	input wire        aclk,
	input wire        aresetn,
	input wire        flash_rd_req,
	input wire [7:0]  fl_byte,
	input wire        fl_slow,
	output reg        flash_rd_ack,
	output reg [7:0]  flash_rdata
);
	reg        pend_q;
	reg [3:0]  cnt_q;
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pend_q <= 1'b0;
			cnt_q <= 4'h0;
			flash_rd_ack <= 1'b0;
			flash_rdata <= 8'h5a;
		end
		else
		begin
			// Idle data toggles so a stale byte is never taken for a fresh one
			flash_rd_ack <= 1'b0;
			flash_rdata <= ~flash_rdata;
			if (flash_rd_req)
			begin
				pend_q <= 1'b1;
				cnt_q <= fl_slow ? 4'h5 : 4'h0;
			end
			else if (pend_q && cnt_q == 4'h0)
			begin
				flash_rd_ack <= 1'b1;
				flash_rdata <= fl_byte;
				pend_q <= 1'b0;
			end
			else if (pend_q)
				cnt_q <= cnt_q - 4'h1;
		end
	end
endmodule

// >>> verification/testbench.sv
// Self-checking bench of the ISP block
`timescale 1ns/100ps
`include "ifb_map.vh"
module testbench;
	reg         aclk = 1'b0;
	reg         aresetn = 1'b0;
	reg  [4:0]  s_axi_awaddr = 5'h00;
	reg  [4:0]  s_axi_araddr = 5'h00;
	reg  [2:0]  s_axi_awprot = 3'h0;
	reg  [2:0]  s_axi_arprot = 3'h0;
	reg         s_axi_awvalid = 1'b0;
	reg         s_axi_wvalid = 1'b0;
	reg         s_axi_bready = 1'b0;
	reg         s_axi_arvalid = 1'b0;
	reg         s_axi_rready = 1'b0;
	reg  [31:0] s_axi_wdata = 32'h0;
	reg  [3:0]  s_axi_wstrb = 4'hf;
	reg         instr_cycle = 1'b0;
	reg         emu_mode = 1'b0;
	reg         emu_break = 1'b0;
	reg         jump_to_boot_instr = 1'b0;
	reg         return_to_flash_instr = 1'b0;
	reg  [7:0]  fl_byte = 8'h00;
	reg         fl_slow = 1'b0;
	wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0]  s_axi_bresp, s_axi_rresp, flash_op;
	wire [31:0] s_axi_rdata;
	wire        flash_rd_req, flash_rd_ack, flash_pgm_pulse;
	wire        jump_go_boot, jump_go_flash, exec_from_boot;
	wire [7:0]  flash_rdata, flash_wdata;
	integer     fails = 0;
	integer     n_checks = 0;
	integer     pw = 0;
	integer     pw0 = 0;
	integer     i, k;
	reg  [31:0] rng = 32'h00000d02;
	reg  [31:0] rd;
	reg  [1:0]  rs, opv;
	reg  [7:0]  d;

	ifb_top dut (.*);
	ifb_flash_model fm (.*);

	always #12.5 aclk = ~aclk;
	always @(posedge aclk)
		if (flash_pgm_pulse)
		begin
			pw <= pw + 1;
			opv <= flash_op;
		end

	function [31:0] xs(input [31:0] s);
		reg [31:0] t;
		begin
			t = s ^ (s << 13);
			t = t ^ (t >> 17);
			xs = t ^ (t << 5);
		end
	endfunction

	task chk(input string nm, input [31:0] e, input [31:0] g);
		begin
			n_checks = n_checks + 1;
			if (g !== e)
			begin
				fails = fails + 1;
				$display("[FAIL] %0s expected %h seen %h", nm, e, g);
			end
		end
	endtask

	// Callers enter just after a rising edge and leave the same way
	task wr(input [4:0] a, input [7:0] v);
		begin
			s_axi_awaddr <= a;
			s_axi_wdata <= {24'h0, v};
			s_axi_awvalid <= 1'b1;
			s_axi_wvalid <= 1'b1;
			s_axi_bready <= 1'b1;
			do
			begin
				@(posedge aclk);
				if (s_axi_awready)
					s_axi_awvalid <= 1'b0;
				if (s_axi_wready)
					s_axi_wvalid <= 1'b0;
			end while (!s_axi_bvalid);
			rs = s_axi_bresp;
			s_axi_bready <= 1'b0;
			@(posedge aclk);
		end
	endtask

	task rdr(input [4:0] a);
		begin
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'b1;
			s_axi_rready <= 1'b1;
			do
			begin
				@(posedge aclk);
				if (s_axi_arready)
					s_axi_arvalid <= 1'b0;
			end while (!s_axi_rvalid);
			rd = s_axi_rdata;
			rs = s_axi_rresp;
			s_axi_rready <= 1'b0;
			@(posedge aclk);
		end
	endtask

	task ic(input integer n);
		repeat (n)
		begin
			instr_cycle <= 1'b1;
			@(posedge aclk);
			instr_cycle <= 1'b0;
			@(posedge aclk);
		end
	endtask

	task jmp(input e);
		begin
			jump_to_boot_instr <= 1'b1;
			@(posedge aclk);
			jump_to_boot_instr <= 1'b0;
			#1;
			chk("go_boot", e, jump_go_boot);
			chk("go_flash", !e, jump_go_flash);
			@(posedge aclk);
		end
	endtask

	task end_sim;
		begin
			$display("checks %0d mismatches %0d", n_checks, fails);
			if (fails == 0 && n_checks > 0)
				$display("TB: PASS");
			else
				$display("TB: FAIL");
			$finish;
		end
	endtask

	initial
	begin
		repeat (40000) @(posedge aclk);
		fails = fails + 1;
		end_sim;
	end

	initial
	begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rdr(`IFB_OFS_PROGRAM_PULSE_TIMING);
		chk("timing reset", {24'h0, `IFB_PROGRAM_PULSE_TIMING_RST}, rd);
		rdr(5'h14);
		chk("unmapped", `IFB_RESP_SLVERR, rs);
		wr(5'h14, 8'h00);
		chk("unmapped wr", `IFB_RESP_SLVERR, rs);
		for (i = 0; i < 4; i = i + 1)
		begin
			rng = xs(rng);
			d = rng[7:0] | (i == 0 ? 8'h80 : 8'h00);
			wr(`IFB_OFS_WDATA, d);
			rdr(`IFB_OFS_WDATA);
			chk("write data", {24'h0, d}, rd);
			chk("flash wdata", d, flash_wdata);
			wr(`IFB_OFS_PROGRAM_PULSE_TIMING, d);
			rdr(`IFB_OFS_PROGRAM_PULSE_TIMING);
			chk("timing", {24'h0, d & `IFB_PROGRAM_PULSE_TIMING_RW}, rd);
			fl_byte <= rng[15:8];
			fl_slow <= rng[16];
			wr(`IFB_OFS_CTRL, 8'h01);
			// Poll busy first: a slow ack would otherwise race the data read
			k = 0;
			do
			begin
				rdr(`IFB_OFS_CTRL);
				k = k + 1;
			end while (rd[0] !== 1'b0 && k < 20);
			chk("read done", 0, rd[0]);
			rdr(`IFB_OFS_RDATA);
			chk("read data", {24'h0, fl_byte}, rd);
		end
		$display("register and read tests done");
		for (i = 1; i < 4; i = i + 1)
		begin
			rng = xs(rng);
			d = {6'h0, rng[1:0]} + 8'h1;
			wr(`IFB_OFS_PROGRAM_PULSE_TIMING, d);
			pw0 = pw;
			wr(`IFB_OFS_CTRL, 8'h01 << i);
			// Data and timing left alone while the operation runs
			for (k = 0; k < 300 && flash_op !== 2'h0; k = k + 1)
				@(posedge aclk);
			chk("pulse width", d * `IFB_PULSE_UNIT, pw - pw0);
			chk("op code", i, opv);
		end
		pw0 = pw;
		wr(`IFB_OFS_CTRL, 8'h02);
		for (k = 0; k < 300 && flash_op !== 2'h0; k = k + 1)
			@(posedge aclk);
		chk("pulse again", d * `IFB_PULSE_UNIT, pw - pw0);
		$display("pulse tests done");
		wr(`IFB_OFS_KEY, {`IFB_KEY_PATTERN, rng[3:2]});
		rdr(`IFB_OFS_KEY);
		chk("unlocked", 1, rd[1]);
		ic(7);
		jmp(1'b1);
		return_to_flash_instr <= 1'b1;
		@(posedge aclk);
		return_to_flash_instr <= 1'b0;
		#1;
		chk("exec boot", 0, exec_from_boot);
		@(posedge aclk);
		ic(1);
		jmp(1'b0);
		wr(`IFB_OFS_KEY, {`IFB_KEY_PATTERN ^ (6'h1 << (rng % 6)), rng[5:4]});
		rdr(`IFB_OFS_KEY);
		chk("mismatch", 0, rd[1]);
		jmp(1'b0);
		wr(`IFB_OFS_KEY, {`IFB_KEY_PATTERN, 2'h3});
		emu_mode <= 1'b1;
		emu_break <= 1'b1;
		ic(9);
		rdr(`IFB_OFS_KEY);
		chk("frozen", 1, rd[1]);
		emu_break <= 1'b0;
		ic(8);
		rdr(`IFB_OFS_KEY);
		chk("expired", 0, rd[1]);
		$display("unlock tests done");
		end_sim;
	end
endmodule
